// File: design/imc_pkg.sv
// package: register map, reset values and mode codes of the input mapping control block

package imc_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int NUM_IN = 2;
	localparam int SYNC_STAGES = 2;
	localparam int ADDR_W = 8;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_MAP_IN0 = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_MAP_IN1 = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IN_MON = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_HW_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// reset values and fields
	// ----------------------------------------------------------------
	localparam logic [NUM_CH-1:0] RST_OUT_CTRL = 8'h00;
	localparam logic [NUM_CH-1:0] RST_MAP_IN0 = 8'h04;
	localparam logic [NUM_CH-1:0] RST_MAP_IN1 = 8'h08;
	localparam logic RST_ACTIVE = 1'b0;
	localparam int HW_ACT_BIT = 0;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_VDD_UV_BIT = 2;
	localparam int ST_VS_UV_BIT = 3;
	localparam int ST_LOWBAT_BIT = 4;
	localparam int ST_SERIAL_EN_BIT = 5;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SLEEP,
		MODE_IDLE,
		MODE_ACTIVE,
		MODE_FAILSAFE
	} imc_mode_e;

endpackage

// File: design/imc_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none

module imc_sync #(
	parameter int WIDTH = 6,
	parameter int STAGES = imc_pkg::SYNC_STAGES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_r [STAGES];

	// first stage feeds only the next stage
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_r[i] <= '0;
			end
		end else begin
			stage_r[0] <= async_in;
			for (int i = 1; i < STAGES; i++) begin
				stage_r[i] <= stage_r[i-1];
			end
		end
	end

	assign sync_out = stage_r[STAGES-1];

endmodule

`default_nettype wire

// File: design/imc_ctrl.sv
// input mapping, mode control and supply gating with an apb register port
`timescale 1ns/1ns
`default_nettype none

module imc_ctrl #(
	parameter int NUM_CH = imc_pkg::NUM_CH
) (
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and supply monitors, all asynchronous
	input wire logic direct_input_0,
	input wire logic direct_input_1,
	input wire logic low_power_req,
	input wire logic vdd_uv,
	input wire logic vs_uv,
	input wire logic low_battery_operation,
	// outputs
	output logic [NUM_CH-1:0] channel_drive,
	output logic [1:0] mode,
	output logic uv_detect_en,
	output logic serial_link_en
);

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	localparam int NSYNC = 6;

	wire [NSYNC-1:0] pins_async;
	wire [NSYNC-1:0] pins_sync;

	// the request pin is carried inverted, so a cleared synchroniser
	// reads as no request and reset is not followed by a false sleep
	assign pins_async = {low_battery_operation, vs_uv, vdd_uv,
		~low_power_req, direct_input_1, direct_input_0};

	imc_sync #(
		.WIDTH(NSYNC),
		.STAGES(imc_pkg::SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	wire in0_s;
	wire in1_s;
	wire lp_req_s;
	wire vdd_uv_s;
	wire vs_uv_s;
	wire lowbat_s;

	assign in0_s = pins_sync[0];
	assign in1_s = pins_sync[1];
	assign lp_req_s = ~pins_sync[2];
	assign vdd_uv_s = pins_sync[3];
	assign vs_uv_s = pins_sync[4];
	assign lowbat_s = pins_sync[5];

	// ----------------------------------------------------------------
	// supply and pin conditions
	// ----------------------------------------------------------------
	wire any_in;
	wire sleep_cond;
	wire fail_cond;
	wire both_uv;
	wire reg_clear;
	wire serial_block;

	assign any_in = in0_s | in1_s;
	assign sleep_cond = ~lp_req_s & ~any_in;
	assign fail_cond = ~lp_req_s & any_in;
	assign both_uv = vdd_uv_s & vs_uv_s;

	// a held-low request pin keeps registers cleared, not just once
	assign reg_clear = srst | ~lp_req_s | vdd_uv_s | both_uv;
	// sleep and logic undervoltage both refuse the bus
	assign serial_block = sleep_cond | vdd_uv_s | both_uv;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0] out_ctrl_r;
	logic [NUM_CH-1:0] map_r [imc_pkg::NUM_IN];
	logic active_r;

	wire [imc_pkg::ADDR_W-1:0] addr;
	wire hit_out;
	wire hit_map0;
	wire hit_map1;
	wire hit_mon;
	wire hit_hw;
	wire hit_st;
	wire hit_any;
	wire wr_en;
	wire setup;

	assign addr = paddr[imc_pkg::ADDR_W-1:0];
	assign hit_out = (addr == imc_pkg::ADDR_OUT_CTRL);
	assign hit_map0 = (addr == imc_pkg::ADDR_MAP_IN0);
	assign hit_map1 = (addr == imc_pkg::ADDR_MAP_IN1);
	assign hit_mon = (addr == imc_pkg::ADDR_IN_MON);
	assign hit_hw = (addr == imc_pkg::ADDR_HW_CTRL);
	assign hit_st = (addr == imc_pkg::ADDR_STATUS);
	assign hit_any = (hit_out | hit_map0 | hit_map1 | hit_mon | hit_hw | hit_st)
		& (paddr[31:imc_pkg::ADDR_W] == '0);
	assign setup = psel & ~penable;
	// a write lands only in the access cycle that the answer closes
	assign wr_en = psel & penable & pready & pwrite & hit_any & ~serial_block;

	always_ff @(posedge clk) begin
		if (reg_clear) begin
			out_ctrl_r <= imc_pkg::RST_OUT_CTRL;
		end else if (wr_en && hit_out) begin
			out_ctrl_r <= pwdata[NUM_CH-1:0];
		end
	end

	// one mapping register per input, default set in the package
	wire [NUM_CH-1:0] map_rst [imc_pkg::NUM_IN];
	wire hit_map [imc_pkg::NUM_IN];

	assign map_rst[0] = imc_pkg::RST_MAP_IN0;
	assign map_rst[1] = imc_pkg::RST_MAP_IN1;
	assign hit_map[0] = hit_map0;
	assign hit_map[1] = hit_map1;

	for (genvar g = 0; g < imc_pkg::NUM_IN; g++) begin : g_map
		always_ff @(posedge clk) begin
			if (reg_clear) begin
				map_r[g] <= map_rst[g];
			end else if (wr_en && hit_map[g]) begin
				map_r[g] <= pwdata[NUM_CH-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reg_clear) begin
			active_r <= imc_pkg::RST_ACTIVE;
		end else if (wr_en && hit_hw) begin
			active_r <= pwdata[imc_pkg::HW_ACT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// mode decision
	// ----------------------------------------------------------------
	imc_pkg::imc_mode_e mode_nxt;
	wire sw_active;

	// active needs the software bit or a channel commanded on
	assign sw_active = active_r | (out_ctrl_r != '0);

	always_comb begin
		if (sleep_cond) begin
			mode_nxt = imc_pkg::MODE_SLEEP;
		end else if (fail_cond) begin
			mode_nxt = imc_pkg::MODE_FAILSAFE;
		end else if (sw_active) begin
			mode_nxt = imc_pkg::MODE_ACTIVE;
		end else begin
			mode_nxt = imc_pkg::MODE_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// channel drive
	// ----------------------------------------------------------------
	wire [NUM_CH-1:0] map_req;
	wire [NUM_CH-1:0] fail_req;
	logic [NUM_CH-1:0] drive_r;
	logic [NUM_CH-1:0] drive_nxt;
	wire drive_kill;

	assign map_req = out_ctrl_r
		| (in0_s ? map_r[0] : '0)
		| (in1_s ? map_r[1] : '0);

	// fail-safe ignores programmed maps, only the fixed defaults count
	assign fail_req = (in0_s ? imc_pkg::RST_MAP_IN0 : '0)
		| (in1_s ? imc_pkg::RST_MAP_IN1 : '0);

	// battery undervoltage wins over every mode, fail-safe too
	assign drive_kill = vs_uv_s | both_uv;

	always_comb begin
		case (mode_nxt)
			imc_pkg::MODE_SLEEP: drive_nxt = '0;
			imc_pkg::MODE_FAILSAFE: drive_nxt = fail_req;
			imc_pkg::MODE_IDLE,
			imc_pkg::MODE_ACTIVE: drive_nxt = map_req;
			default: drive_nxt = '0;
		endcase
		if (drive_kill) begin
			drive_nxt = '0;
		end else if (lowbat_s) begin
			// switching on may fail at low battery; model it as never
			drive_nxt = drive_nxt & drive_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic [1:0] mode_r;
	logic uv_en_r;
	logic serial_en_r;

	// outputs come from flops so the pins never see decode glitches
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_r <= '0;
			mode_r <= imc_pkg::MODE_IDLE;
			uv_en_r <= 1'b1;
			serial_en_r <= 1'b0;
		end else begin
			drive_r <= drive_nxt;
			mode_r <= mode_nxt;
			uv_en_r <= ~sleep_cond;
			serial_en_r <= ~serial_block;
		end
	end

	assign channel_drive = drive_r;
	assign mode = mode_r;
	assign uv_detect_en = uv_en_r;
	assign serial_link_en = serial_en_r;

	// ----------------------------------------------------------------
	// apb read side
	// ----------------------------------------------------------------
	wire [31:0] mon_word;
	logic [31:0] st_word;
	logic [31:0] rd_mux;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	wire rd_ok;
	wire acc_err;

	assign mon_word = {30'h0, in1_s, in0_s};

	// status fields placed by the package positions
	always_comb begin
		st_word = '0;
		st_word[imc_pkg::ST_MODE_LSB +: $bits(mode_r)] = mode_r;
		st_word[imc_pkg::ST_VDD_UV_BIT] = vdd_uv_s;
		st_word[imc_pkg::ST_VS_UV_BIT] = vs_uv_s;
		st_word[imc_pkg::ST_LOWBAT_BIT] = lowbat_s;
		st_word[imc_pkg::ST_SERIAL_EN_BIT] = serial_en_r;
	end

	always_comb begin
		rd_mux = '0;
		if (hit_out) begin
			rd_mux[NUM_CH-1:0] = out_ctrl_r;
		end else if (hit_map0) begin
			rd_mux[NUM_CH-1:0] = map_r[0];
		end else if (hit_map1) begin
			rd_mux[NUM_CH-1:0] = map_r[1];
		end else if (hit_mon) begin
			rd_mux = mon_word;
		end else if (hit_hw) begin
			rd_mux[imc_pkg::HW_ACT_BIT] = active_r;
		end else if (hit_st) begin
			rd_mux = st_word;
		end
	end

	// refused accesses still answer at once, flagged by the error
	assign acc_err = setup & (~hit_any | serial_block);
	assign rd_ok = setup & hit_any & ~serial_block & ~pwrite;

	// answer is prepared in setup, so every access takes two cycles, setup plus one access cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= setup;
			pslverr_r <= acc_err;
			prdata_r <= rd_ok ? rd_mux : '0;
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;

endmodule

`default_nettype wire

// File: testbench/imc_host.sv
// host model: drives the control pins of the block
`timescale 1ns/1ns
`default_nettype none
module imc_host #(
	parameter int MIN_HOLD = 4
) (
	input wire logic clk,
	input wire logic want_req,
	input wire logic [1:0] want_in,
	output var logic low_power_req,
	output var logic direct_input_0,
	output var logic direct_input_1
);
	int held = 99;
	initial begin
		low_power_req = 1'h1;
		direct_input_0 = 1'h0;
		direct_input_1 = 1'h0;
	end
	// request pin moves only after its old level was held long enough
	always @(posedge clk) begin
		if (want_req !== low_power_req && held >= MIN_HOLD) begin
			low_power_req <= want_req;
			held <= 0;
		end else begin
			held <= held + 1;
		end
		{direct_input_1, direct_input_0} <= want_in;
	end
endmodule
`default_nettype wire

// File: testbench/imc_ctrl_sva.sv
// checker: port assertions of the input mapping control block
`timescale 1ns/1ns
`default_nettype none
module imc_ctrl_chk #(
	parameter int NUM_CH = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic direct_input_0,
	input wire logic direct_input_1,
	input wire logic low_power_req,
	input wire logic vdd_uv,
	input wire logic vs_uv,
	input wire logic low_battery_operation,
	input wire logic [NUM_CH-1:0] channel_drive,
	input wire logic [1:0] mode,
	input wire logic uv_detect_en,
	input wire logic serial_link_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire sl = !low_power_req && !direct_input_0 && !direct_input_1;
	wire fs = !low_power_req && (direct_input_0 || direct_input_1);
	wire ok = !vs_uv && !low_battery_operation;
	wire [2:0] pins = {low_power_req, direct_input_1, direct_input_0};
	wire [7:0] fs_drive = {4'h0, direct_input_1, direct_input_0, 2'h0};
	AST_SLEEP_MODE: assert property (sl [*4] |-> mode == 2'h0)
		else $error("mode not sleep");
	AST_SLEEP_UV: assert property (sl [*4] |-> !uv_detect_en)
		else $error("detectors on in sleep");
	AST_SLEEP_LINK: assert property (sl [*4] |-> !serial_link_en)
		else $error("link on in sleep");
	AST_FS_MODE: assert property ((fs && $stable(pins)) [*4] |-> mode == 2'h3)
		else $error("mode not fail-safe");
	AST_FS_DRIVE: assert property ((fs && ok && $stable(pins)) [*4] |->
		channel_drive == fs_drive) else $error("fail-safe drive");
	AST_VS_OFF: assert property (vs_uv [*4] |-> channel_drive == '0)
		else $error("channels on in battery uv");
	AST_VDD_LINK: assert property (vdd_uv [*4] |-> !serial_link_en)
		else $error("link on in logic uv");
	AST_BOTH_UV: assert property ((vdd_uv && vs_uv) [*4] |->
		channel_drive == '0 && !serial_link_en) else $error("both uv");
	AST_LOWBAT: assert property (low_battery_operation [*5] |->
		(channel_drive & ~$past(channel_drive)) == '0) else $error("new channel at low battery");
	AST_ANSWER: assert property (psel && !penable |=> pready)
		else $error("no answer");
	cover property (fs [*4]);
	cover property (sl [*4] ##0 psel);
	cover property (low_battery_operation && channel_drive != '0);
	cover property (mode == 2'h2 && channel_drive == '0);
endmodule
bind imc_ctrl imc_ctrl_chk #(.NUM_CH(NUM_CH)) chk (
	.clk(clk),
	.srst(srst),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.direct_input_0(direct_input_0),
	.direct_input_1(direct_input_1),
	.low_power_req(low_power_req),
	.vdd_uv(vdd_uv),
	.vs_uv(vs_uv),
	.low_battery_operation(low_battery_operation),
	.channel_drive(channel_drive),
	.mode(mode),
	.uv_detect_en(uv_detect_en),
	.serial_link_en(serial_link_en)
);
`default_nettype wire

// File: testbench/imc_ctrl_test.sv
// testbench: register and pin scenarios of the input mapping control block
`timescale 1ns/1ns
`default_nettype none
module imc_ctrl_test;
	localparam int HOLD = 4;
	logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic pready, pslverr, err, low_power_req, direct_input_0, direct_input_1;
	logic want_req = 1'h1, vdd_uv = 1'h0, vs_uv = 1'h0, low_battery_operation = 1'h0;
	logic [1:0] want_in = '0, mode;
	logic [7:0] channel_drive;
	logic uv_detect_en, serial_link_en;
	int fail_count = 0, checks_done = 0;
	initial forever #20 clk = ~clk;
	imc_host #(.MIN_HOLD(HOLD)) host (
		.clk(clk),
		.want_req(want_req),
		.want_in(want_in),
		.low_power_req(low_power_req),
		.direct_input_0(direct_input_0),
		.direct_input_1(direct_input_1)
	);
	imc_ctrl DUT (
		.clk(clk),
		.srst(srst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.direct_input_0(direct_input_0),
		.direct_input_1(direct_input_1),
		.low_power_req(low_power_req),
		.vdd_uv(vdd_uv),
		.vs_uv(vs_uv),
		.low_battery_operation(low_battery_operation),
		.channel_drive(channel_drive),
		.mode(mode),
		.uv_detect_en(uv_detect_en),
		.serial_link_en(serial_link_en)
	);
	task automatic complete_run();
		if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			fail_count++;
			$display("wrong value at %0t: no pready", $time);
			complete_run();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			// idle edge so the next call never sets a strobe twice in one step
			@(posedge clk);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic e);
		apb(1'h0, a, 8'h00);
		check(rd[7:0], exp);
		check({7'h0, err}, {7'h0, e});
	endtask
	// covers the request hold plus six more edges, enough for the two synchroniser stages and the output flop
	task automatic settle();
		repeat (HOLD + 6) @(posedge clk);
	endtask
	task automatic pins(input logic r, input logic [1:0] i);
		want_req <= r;
		want_in <= i;
		settle();
	endtask
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		pins(1'h1, 2'h0);
		rchk(8'h04, 8'h04, 1'h0);
		rchk(8'h08, 8'h08, 1'h0);
		pins(1'h1, 2'h3);
		check(channel_drive, 8'h0C);
		rchk(8'h0C, 8'h03, 1'h0);
		apb(1'h1, 8'h04, 8'h81);
		apb(1'h1, 8'h08, 8'h50);
		apb(1'h1, 8'h00, 8'h20);
		pins(1'h1, 2'h1);
		check(channel_drive, 8'hA1);
		check({6'h0, mode}, 8'h02);
		pins(1'h1, 2'h2);
		check(channel_drive, 8'h70);
		rchk(8'h18, 8'h00, 1'h1);
		apb(1'h1, 8'h00, 8'h00);
		pins(1'h1, 2'h0);
		check({6'h0, mode}, 8'h01);
		apb(1'h1, 8'h10, 8'h01);
		rchk(8'h10, 8'h01, 1'h0);
		check({6'h0, mode}, 8'h02);
		rchk(8'h14, 8'h22, 1'h0);
		check(channel_drive, 8'h00);
		pins(1'h0, 2'h1);
		check({6'h0, mode}, 8'h03);
		check(channel_drive, 8'h04);
		check({6'h0, uv_detect_en, serial_link_en}, 8'h03);
		rchk(8'h0C, 8'h01, 1'h0);
		apb(1'h1, 8'h04, 8'hFF);
		rchk(8'h04, 8'h04, 1'h0);
		pins(1'h0, 2'h0);
		check({4'h0, mode, uv_detect_en, serial_link_en}, 8'h00);
		rchk(8'h00, 8'h00, 1'h1);
		pins(1'h1, 2'h0);
		rchk(8'h08, 8'h08, 1'h0);
		apb(1'h1, 8'h00, 8'h01);
		vdd_uv <= 1'h1;
		settle();
		rchk(8'h00, 8'h00, 1'h1);
		vdd_uv <= 1'h0;
		settle();
		rchk(8'h00, 8'h00, 1'h0);
		apb(1'h1, 8'h00, 8'h11);
		vs_uv <= 1'h1;
		settle();
		check(channel_drive, 8'h00);
		vs_uv <= 1'h0;
		settle();
		check(channel_drive, 8'h11);
		low_battery_operation <= 1'h1;
		settle();
		apb(1'h1, 8'h00, 8'h13);
		settle();
		check(channel_drive, 8'h11);
		apb(1'h1, 8'h00, 8'h10);
		settle();
		check(channel_drive, 8'h10);
		low_battery_operation <= 1'h0;
		vdd_uv <= 1'h1;
		vs_uv <= 1'h1;
		settle();
		check(channel_drive | {7'h0, serial_link_en}, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
